// ### logic/host_event_status_flags.sv
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ns
`include "host_event_regs.svh"
module host_event_status_flags #(
	parameter int DESC_COUNT = 32
) (
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic [11:0]           s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [11:0]           s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	input  wire logic                  dual_role_event,
	input  wire logic [DESC_COUNT-1:0] iso_desc_done,
	input  wire logic [DESC_COUNT-1:0] async_desc_done,
	input  wire logic [DESC_COUNT-1:0] int_desc_done,
	input  wire logic                  clocks_stable,
	input  wire logic                  host_suspended,
	input  wire logic                  dma_transfer_done,
	input  wire logic                  frame_start,
	output logic                       irq
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic host_event_pkg::word_t strb_bits(host_event_pkg::strb_t s);
		strb_bits = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
	endfunction

	function automatic host_event_pkg::word_t merge(
		host_event_pkg::word_t old_val,
		host_event_pkg::word_t new_val,
		host_event_pkg::strb_t s
	);
		merge = (old_val & ~strb_bits(s)) | (new_val & strb_bits(s));
	endfunction

	// ----------------------------------------------------------------
	// register bus
	// ----------------------------------------------------------------
	reg_access_if regs ();

	axil_reg_slave u_slave (
		.aclk          (aclk),
		.aresetn       (aresetn),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.regs          (regs)
	);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	host_event_pkg::word_t host_event_flags, next_host_event_flags;
	host_event_pkg::word_t host_event_enables, next_host_event_enables;
	logic [DESC_COUNT-1:0] iso_and_mask, next_iso_and_mask;
	logic [DESC_COUNT-1:0] iso_or_mask, next_iso_or_mask;
	logic [DESC_COUNT-1:0] async_and_mask, next_async_and_mask;
	logic [DESC_COUNT-1:0] async_or_mask, next_async_or_mask;
	logic [DESC_COUNT-1:0] int_and_mask, next_int_and_mask;
	logic [DESC_COUNT-1:0] int_or_mask, next_int_or_mask;
	logic                  clk_sync_a, clk_sync_b, clk_seen;
	logic                  next_clk_sync_a, next_clk_sync_b, next_clk_seen;
	logic                  susp_seen, next_susp_seen;
	logic                  next_irq;
	host_event_pkg::word_t set_vec, clear_vec;
	logic                  iso_hit, async_hit, int_hit;
	logic [DESC_COUNT-1:0] iso_pending, async_pending, int_pending;

	// ----------------------------------------------------------------
	// descriptor completion combining
	// ----------------------------------------------------------------
	list_done_combiner #(.DESC_COUNT(DESC_COUNT)) u_iso (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.done_vec (iso_desc_done),
		.and_mask (iso_and_mask),
		.or_mask  (iso_or_mask),
		.hit      (iso_hit),
		.pending  (iso_pending)
	);

	list_done_combiner #(.DESC_COUNT(DESC_COUNT)) u_async (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.done_vec (async_desc_done),
		.and_mask (async_and_mask),
		.or_mask  (async_or_mask),
		.hit      (async_hit),
		.pending  (async_pending)
	);

	list_done_combiner #(.DESC_COUNT(DESC_COUNT)) u_int (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.done_vec (int_desc_done),
		.and_mask (int_and_mask),
		.or_mask  (int_or_mask),
		.hit      (int_hit),
		.pending  (int_pending)
	);

	// ----------------------------------------------------------------
	// event sources
	// ----------------------------------------------------------------
	always_comb begin
		// clock status comes from the clock generator, outside this domain
		next_clk_sync_a = clocks_stable;
		next_clk_sync_b = clk_sync_a;
		next_clk_seen   = clk_sync_b;
		next_susp_seen  = host_suspended;
		set_vec = 32'h0000_0000;
		set_vec[`HEF_BIT_DUAL_ROLE]   = dual_role_event;
		set_vec[`HEF_BIT_ISO_DONE]    = iso_hit;
		set_vec[`HEF_BIT_ASYNC_DONE]  = async_hit;
		set_vec[`HEF_BIT_INT_DONE]    = int_hit;
		set_vec[`HEF_BIT_CLK_STABLE]  = clk_sync_b && !clk_seen;
		set_vec[`HEF_BIT_SUSPEND]     = host_suspended && !susp_seen;
		set_vec[`HEF_BIT_DMA_END]     = dma_transfer_done;
		set_vec[`HEF_BIT_FRAME_START] = frame_start;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			clk_sync_a <= 1'b0;
			clk_sync_b <= 1'b0;
			clk_seen   <= 1'b0;
			susp_seen  <= 1'b0;
		end else begin
			clk_sync_a <= next_clk_sync_a;
			clk_sync_b <= next_clk_sync_b;
			clk_seen   <= next_clk_seen;
			susp_seen  <= next_susp_seen;
		end
	end

	// ----------------------------------------------------------------
	// register writes and flag update
	// ----------------------------------------------------------------
	always_comb begin
		next_host_event_enables = host_event_enables;
		next_iso_and_mask       = iso_and_mask;
		next_iso_or_mask        = iso_or_mask;
		next_async_and_mask     = async_and_mask;
		next_async_or_mask      = async_or_mask;
		next_int_and_mask       = int_and_mask;
		next_int_or_mask        = int_or_mask;
		clear_vec               = 32'h0000_0000;
		regs.wr_ok              = 1'b1;
		if (regs.waddr == `HEF_OFS_FLAGS) begin
			// reserved bits are not stored, so a careless write cannot set them
			clear_vec = regs.wr ? (regs.wdata & strb_bits(regs.wstrb)) : 32'h0000_0000;
		end else if (regs.waddr == `HEF_OFS_ENABLES) begin
			if (regs.wr) begin
				next_host_event_enables = merge(host_event_enables, regs.wdata, regs.wstrb)
					& `HEF_DEFINED_MASK;
			end
		end else if (regs.waddr == `HEF_OFS_ISO_AND) begin
			if (regs.wr) begin
				next_iso_and_mask = DESC_COUNT'(merge(32'(iso_and_mask), regs.wdata, regs.wstrb));
			end
		end else if (regs.waddr == `HEF_OFS_ISO_OR) begin
			if (regs.wr) begin
				next_iso_or_mask = DESC_COUNT'(merge(32'(iso_or_mask), regs.wdata, regs.wstrb));
			end
		end else if (regs.waddr == `HEF_OFS_ASYNC_AND) begin
			if (regs.wr) begin
				next_async_and_mask = DESC_COUNT'(merge(32'(async_and_mask), regs.wdata,
					regs.wstrb));
			end
		end else if (regs.waddr == `HEF_OFS_ASYNC_OR) begin
			if (regs.wr) begin
				next_async_or_mask = DESC_COUNT'(merge(32'(async_or_mask), regs.wdata,
					regs.wstrb));
			end
		end else if (regs.waddr == `HEF_OFS_INT_AND) begin
			if (regs.wr) begin
				next_int_and_mask = DESC_COUNT'(merge(32'(int_and_mask), regs.wdata, regs.wstrb));
			end
		end else if (regs.waddr == `HEF_OFS_INT_OR) begin
			if (regs.wr) begin
				next_int_or_mask = DESC_COUNT'(merge(32'(int_or_mask), regs.wdata, regs.wstrb));
			end
		end else if (regs.waddr == `HEF_OFS_LEVELS) begin
			regs.wr_ok = 1'b1;
		end else begin
			regs.wr_ok = 1'b0;
		end
		// an event in the same cycle as its clear wins over the clear
		next_host_event_flags = ((host_event_flags & ~clear_vec) | set_vec)
			& `HEF_DEFINED_MASK;
		next_irq = |(next_host_event_flags & next_host_event_enables);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			host_event_flags   <= `HEF_RESET_FLAGS;
			host_event_enables <= `HEF_RESET_ENABLES;
			iso_and_mask       <= DESC_COUNT'(`HEF_RESET_MASK);
			iso_or_mask        <= DESC_COUNT'(`HEF_RESET_MASK);
			async_and_mask     <= DESC_COUNT'(`HEF_RESET_MASK);
			async_or_mask      <= DESC_COUNT'(`HEF_RESET_MASK);
			int_and_mask       <= DESC_COUNT'(`HEF_RESET_MASK);
			int_or_mask        <= DESC_COUNT'(`HEF_RESET_MASK);
			irq                <= 1'b0;
		end else begin
			host_event_flags   <= next_host_event_flags;
			host_event_enables <= next_host_event_enables;
			iso_and_mask       <= next_iso_and_mask;
			iso_or_mask        <= next_iso_or_mask;
			async_and_mask     <= next_async_and_mask;
			async_or_mask      <= next_async_or_mask;
			int_and_mask       <= next_int_and_mask;
			int_or_mask        <= next_int_or_mask;
			irq                <= next_irq;
		end
	end

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	always_comb begin
		regs.rdata = 32'h0000_0000;
		regs.rd_ok = 1'b1;
		if (regs.raddr == `HEF_OFS_FLAGS) begin
			regs.rdata = host_event_flags;
		end else if (regs.raddr == `HEF_OFS_ENABLES) begin
			regs.rdata = host_event_enables;
		end else if (regs.raddr == `HEF_OFS_ISO_AND) begin
			regs.rdata = 32'(iso_and_mask);
		end else if (regs.raddr == `HEF_OFS_ISO_OR) begin
			regs.rdata = 32'(iso_or_mask);
		end else if (regs.raddr == `HEF_OFS_ASYNC_AND) begin
			regs.rdata = 32'(async_and_mask);
		end else if (regs.raddr == `HEF_OFS_ASYNC_OR) begin
			regs.rdata = 32'(async_or_mask);
		end else if (regs.raddr == `HEF_OFS_INT_AND) begin
			regs.rdata = 32'(int_and_mask);
		end else if (regs.raddr == `HEF_OFS_INT_OR) begin
			regs.rdata = 32'(int_or_mask);
		end else if (regs.raddr == `HEF_OFS_LEVELS) begin
			// live levels: bit0 clocks stable, bit1 suspended, bit2 irq,
			// bits 3..5 an AND group of iso/async/int has partial progress
			regs.rdata = {26'h0, (|int_pending), (|async_pending), (|iso_pending),
				irq, susp_seen, clk_seen};
		end else begin
			regs.rd_ok = 1'b0;
		end
	end

endmodule // host_event_status_flags

// ### logic/host_event_regs.svh
// Function
// - Set dual-role event flag, bit 10, on each dual-role event; zero means none seen.
// - Interrupt line driven by a flag only while its enable bit is one.
// - Set isochronous done flag, bit 9, on one done or AND/OR mask match.
// - Set async list done flag, bit 8, on one done or AND/OR mask match.
// - Set interrupt list done flag, bit 7, on one done or AND/OR mask match.
// - Set clock stable flag, bit 6, once internal clocks run steadily.
// - Set host suspend flag, bit 5, when host controller enters suspend.
// - Set DMA end flag, bit 3, when a DMA transfer finishes.
// - Set frame start flag, bit 1, on every host start-of-frame event.
// - Enable register at 0x314 gates the interrupt line bit for bit.
`ifndef HOST_EVENT_REGS_SVH
`define HOST_EVENT_REGS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define HEF_OFS_FLAGS       12'h310
`define HEF_OFS_ENABLES     12'h314
`define HEF_OFS_ISO_AND     12'h320
`define HEF_OFS_ISO_OR      12'h324
`define HEF_OFS_ASYNC_AND   12'h328
`define HEF_OFS_ASYNC_OR    12'h32c
`define HEF_OFS_INT_AND     12'h330
`define HEF_OFS_INT_OR      12'h334
`define HEF_OFS_LEVELS      12'h338

// ----------------------------------------------------------------
// flag bit positions
// ----------------------------------------------------------------
`define HEF_BIT_DUAL_ROLE   10
`define HEF_BIT_ISO_DONE    9
`define HEF_BIT_ASYNC_DONE  8
`define HEF_BIT_INT_DONE    7
`define HEF_BIT_CLK_STABLE  6
`define HEF_BIT_SUSPEND     5
`define HEF_BIT_DMA_END     3
`define HEF_BIT_FRAME_START 1

// bits that exist; everything else is reserved and reads zero
`define HEF_DEFINED_MASK    32'h0000_07ea

// ----------------------------------------------------------------
// reset values and bus answers
// ----------------------------------------------------------------
`define HEF_RESET_FLAGS     32'h0000_0000
`define HEF_RESET_ENABLES   32'h0000_0000
`define HEF_RESET_MASK      32'h0000_0000
`define HEF_RESP_OKAY       2'h0
`define HEF_RESP_SLVERR     2'h2

`endif

// ### logic/host_event_pkg.sv
package host_event_pkg;
	typedef logic [31:0] word_t;
	typedef logic [3:0]  strb_t;
	typedef logic [1:0]  resp_t;
endpackage

// ### logic/reg_access_if.sv
`timescale 1ns/1ns
interface reg_access_if;
	logic                 wr;
	logic [11:0]          waddr;
	host_event_pkg::word_t wdata;
	host_event_pkg::strb_t wstrb;
	logic                 wr_ok;
	logic [11:0]          raddr;
	host_event_pkg::word_t rdata;
	logic                 rd_ok;

	modport bus_end (
		output wr,
		output waddr,
		output wdata,
		output wstrb,
		output raddr,
		input  wr_ok,
		input  rdata,
		input  rd_ok
	);
	modport reg_end (
		input  wr,
		input  waddr,
		input  wdata,
		input  wstrb,
		input  raddr,
		output wr_ok,
		output rdata,
		output rd_ok
	);
endinterface // reg_access_if

// ### logic/list_done_combiner.sv
`timescale 1ns/1ns
module list_done_combiner #(
	parameter int DESC_COUNT = 32
) (
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic [DESC_COUNT-1:0] done_vec,
	input  wire logic [DESC_COUNT-1:0] and_mask,
	input  wire logic [DESC_COUNT-1:0] or_mask,
	output logic                       hit,
	output logic [DESC_COUNT-1:0]      pending
);
	logic [DESC_COUNT-1:0] next_pending;
	logic                  next_hit;
	logic                  and_hit;

	always_comb begin
		next_pending = (pending | (done_vec & and_mask)) & and_mask;
		and_hit      = (and_mask != '0) && ((next_pending & and_mask) == and_mask);
		// the whole AND group has to finish again before the next hit
		if (and_hit) begin
			next_pending = '0;
		end
		if ((and_mask == '0) && (or_mask == '0)) begin
			next_hit = |done_vec;
		end else begin
			next_hit = and_hit || (|(done_vec & or_mask));
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pending <= '0;
			hit     <= 1'b0;
		end else begin
			pending <= next_pending;
			hit     <= next_hit;
		end
	end
endmodule // list_done_combiner

// ### logic/axil_reg_slave.sv
`timescale 1ns/1ns
`include "host_event_regs.svh"
module axil_reg_slave (
	input  wire logic                   aclk,
	input  wire logic                   aresetn,
	input  wire logic [11:0]            s_axi_awaddr,
	input  wire logic                   s_axi_awvalid,
	output logic                        s_axi_awready,
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output logic                        s_axi_wready,
	output logic [1:0]                  s_axi_bresp,
	output logic                        s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	input  wire logic [11:0]            s_axi_araddr,
	input  wire logic                   s_axi_arvalid,
	output logic                        s_axi_arready,
	output logic [31:0]                 s_axi_rdata,
	output logic [1:0]                  s_axi_rresp,
	output logic                        s_axi_rvalid,
	input  wire logic                   s_axi_rready,
	reg_access_if.bus_end               regs
);
	logic                  aw_held, next_aw_held, next_awready;
	logic                  w_held, next_w_held, next_wready;
	logic [11:0]           aw_addr, next_aw_addr;
	host_event_pkg::word_t w_data, next_w_data;
	host_event_pkg::strb_t w_strb, next_w_strb;
	logic                  next_bvalid, next_rvalid, next_arready;
	host_event_pkg::resp_t next_bresp, next_rresp;
	host_event_pkg::word_t next_rdata;
	logic                  do_write, ar_fire;

	assign do_write    = aw_held && w_held && !s_axi_bvalid;
	assign ar_fire     = s_axi_arvalid && s_axi_arready;
	assign regs.wr     = do_write;
	assign regs.waddr  = aw_addr;
	assign regs.wdata  = w_data;
	assign regs.wstrb  = w_strb;
	assign regs.raddr  = s_axi_araddr;

	always_comb begin
		next_aw_addr = aw_addr;
		next_w_data  = w_data;
		next_w_strb  = w_strb;
		next_aw_held = aw_held && !do_write;
		next_w_held  = w_held && !do_write;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_held = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		next_awready = !next_aw_held;
		next_wready  = !next_w_held;
		next_bvalid  = s_axi_bvalid && !s_axi_bready;
		next_bresp   = s_axi_bresp;
		if (do_write) begin
			next_bvalid = 1'b1;
			next_bresp  = regs.wr_ok ? `HEF_RESP_OKAY : `HEF_RESP_SLVERR;
		end
		next_rvalid = s_axi_rvalid && !s_axi_rready;
		next_rdata  = s_axi_rdata;
		next_rresp  = s_axi_rresp;
		if (ar_fire) begin
			next_rvalid = 1'b1;
			next_rdata  = regs.rdata;
			next_rresp  = regs.rd_ok ? `HEF_RESP_OKAY : `HEF_RESP_SLVERR;
		end
		// one read outstanding: accept the next address only once rdata is gone
		next_arready = !next_rvalid;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr       <= 12'h000;
			w_data        <= 32'h0000_0000;
			w_strb        <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `HEF_RESP_OKAY;
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `HEF_RESP_OKAY;
		end else begin
			aw_held       <= next_aw_held;
			w_held        <= next_w_held;
			aw_addr       <= next_aw_addr;
			w_data        <= next_w_data;
			w_strb        <= next_w_strb;
			s_axi_awready <= next_awready;
			s_axi_wready  <= next_wready;
			s_axi_bvalid  <= next_bvalid;
			s_axi_bresp   <= next_bresp;
			s_axi_arready <= next_arready;
			s_axi_rvalid  <= next_rvalid;
			s_axi_rdata   <= next_rdata;
			s_axi_rresp   <= next_rresp;
		end
	end
endmodule // axil_reg_slave

// ### tb/host_event_sva.sv
`timescale 1ns/1ns
`include "host_event_regs.svh"
module host_event_sva #(
	parameter int DESC_COUNT = 32
) (
	input wire logic                  aclk,
	input wire logic                  aresetn,
	input wire logic [11:0]           s_axi_awaddr,
	input wire logic                  s_axi_awvalid,
	input wire logic                  s_axi_awready,
	input wire logic [31:0]           s_axi_wdata,
	input wire logic                  s_axi_wvalid,
	input wire logic                  s_axi_wready,
	input wire logic [1:0]            s_axi_bresp,
	input wire logic                  s_axi_bvalid,
	input wire logic                  s_axi_bready,
	input wire logic [1:0]            s_axi_rresp,
	input wire logic                  s_axi_rvalid,
	input wire logic                  dual_role_event,
	input wire logic [DESC_COUNT-1:0] iso_desc_done,
	input wire logic [DESC_COUNT-1:0] async_desc_done,
	input wire logic [DESC_COUNT-1:0] int_desc_done,
	input wire logic                  clocks_stable,
	input wire logic                  host_suspended,
	input wire logic                  dma_transfer_done,
	input wire logic                  frame_start,
	input wire logic                  irq
);
	// ----
	// shadow of the enable register, taken at the write response
	// ----
	logic [11:0] wa, next_wa;
	logic [31:0] wd, next_wd, en, next_en;
	logic        mk, next_mk;
	always_comb begin
		next_wa = wa;
		next_wd = wd;
		next_en = en;
		next_mk = mk;
		if (s_axi_awvalid && s_axi_awready) next_wa = s_axi_awaddr;
		if (s_axi_wvalid && s_axi_wready) next_wd = s_axi_wdata;
		if (s_axi_bvalid && s_axi_bready && wa == `HEF_OFS_ENABLES && s_axi_bresp == `HEF_RESP_OKAY)
			next_en = wd;
		// a nonzero descriptor mask lets single completions pass silently
		if (s_axi_bvalid && s_axi_bready && wa > `HEF_OFS_ENABLES && wa < `HEF_OFS_LEVELS)
			next_mk = mk || (wd != 32'h0);
	end
	always_ff @(posedge aclk) begin
		wa <= aresetn ? next_wa : 12'h0;
		wd <= aresetn ? next_wd : 32'h0;
		en <= aresetn ? next_en : 32'h0;
		mk <= aresetn ? next_mk : 1'b0;
	end
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	AST_DUAL_ROLE: assert property (dual_role_event && en[10] |=> irq)
		else $error("irq missing after dual role event");
	AST_ISO: assert property (|iso_desc_done && en[9] && !mk |-> ##[1:3] irq)
		else $error("irq missing after iso done");
	AST_ASYNC: assert property (|async_desc_done && en[8] && !mk |-> ##[1:3] irq)
		else $error("irq missing after async done");
	AST_INT: assert property (|int_desc_done && en[7] && !mk |-> ##[1:3] irq)
		else $error("irq missing after int done");
	AST_CLK_STABLE: assert property ($rose(clocks_stable) && en[6] |-> ##[1:5] irq)
		else $error("irq missing after clocks stable");
	AST_SUSPEND: assert property ($rose(host_suspended) && en[5] |-> ##[1:2] irq)
		else $error("irq missing after suspend");
	AST_DMA_END: assert property (dma_transfer_done && en[3] |=> irq)
		else $error("irq missing after dma end");
	AST_FRAME: assert property (frame_start && en[1] |=> irq)
		else $error("irq missing after frame start");
	AST_IRQ_GATED: assert property (en == 32'h0 && !s_axi_bvalid |-> !irq)
		else $error("irq high with all enables off");
	AST_IRQ_HOLD: assert property ($fell(irq) |-> !$past(s_axi_awready))
		else $error("irq dropped without a register write");
	COV_IRQ: cover property (irq ##1 !irq);
	COV_WERR: cover property (s_axi_bvalid && s_axi_bresp == `HEF_RESP_SLVERR);
	COV_RERR: cover property (s_axi_rvalid && s_axi_rresp == `HEF_RESP_SLVERR);
endmodule // host_event_sva
bind host_event_status_flags host_event_sva #(.DESC_COUNT(DESC_COUNT)) u_sva (.*);

// ### tb/host_cpu_model.sv
`timescale 1ns/1ns
`include "host_event_regs.svh"
module host_cpu_model (
	input wire logic   aclk,
	output logic [11:0] s_axi_awaddr,
	output logic        s_axi_awvalid,
	input wire logic    s_axi_awready,
	output logic [31:0] s_axi_wdata,
	output logic [3:0]  s_axi_wstrb,
	output logic        s_axi_wvalid,
	input wire logic    s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic    s_axi_bvalid,
	output logic        s_axi_bready,
	output logic [11:0] s_axi_araddr,
	output logic        s_axi_arvalid,
	input wire logic    s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic    s_axi_rvalid,
	output logic        s_axi_rready
);
	int stall = 0;
	initial begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
	end
	// released payloads are inverted so stale values are never mistaken
	task automatic wr(input logic [11:0] a, input host_event_pkg::word_t d,
			output host_event_pkg::resp_t r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d & `HEF_DEFINED_MASK;
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awvalid <= 1'b0;
				s_axi_awaddr <= ~a;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wvalid <= 1'b0;
				s_axi_wdata <= ~d;
			end
		end while (s_axi_awvalid || s_axi_wvalid);
		repeat (stall) @(posedge aclk);
		s_axi_bready <= 1'b1;
		do @(posedge aclk); while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, output host_event_pkg::word_t d,
			output host_event_pkg::resp_t r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		s_axi_araddr <= ~a;
		repeat (stall) @(posedge aclk);
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
endmodule // host_cpu_model

// ### tb/host_event_status_flags_test.sv
`timescale 1ns/1ns
`include "host_event_regs.svh"
module host_event_status_flags_test;
	logic aclk, aresetn, irq;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, dv;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic dual_role_event, clocks_stable, host_suspended, dma_transfer_done, frame_start;
	logic [31:0] iso_desc_done, async_desc_done, int_desc_done;
	logic [7:0] ev;
	int err_total = 0;
	int checked = 0;
	host_event_pkg::word_t rv;
	host_event_pkg::resp_t rs;
	// row i: event i pulsed, flag word it must leave
	host_event_pkg::word_t exp_word [8] = '{32'h400, 32'h200, 32'h100, 32'h80,
		32'h40, 32'h20, 32'h8, 32'h2};
	assign dual_role_event = ev[0];
	assign iso_desc_done = ev[1] ? dv : 32'h0;
	assign async_desc_done = ev[2] ? dv : 32'h0;
	assign int_desc_done = ev[3] ? dv : 32'h0;
	assign clocks_stable = ev[4];
	assign host_suspended = ev[5];
	assign dma_transfer_done = ev[6];
	assign frame_start = ev[7];
	host_event_status_flags u_dut (.*);
	host_cpu_model u_cpu (.*);
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	task automatic summarize();
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input host_event_pkg::word_t got, input host_event_pkg::word_t exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic rdchk(input logic [11:0] a, input host_event_pkg::word_t exp);
		u_cpu.rd(a, rv, rs);
		chk(rv, exp);
	endtask
	// level inputs are raised for one cycle too; only their rising edge counts
	task automatic pulse(input int e);
		@(posedge aclk);
		ev <= 8'h1 << e;
		@(posedge aclk);
		ev <= 8'h0;
		repeat (6) @(posedge aclk);
	endtask
	initial begin
		#100000;
		err_total++;
		summarize();
	end
	initial begin
		aresetn = 1'b0;
		ev = 8'h0;
		dv = 32'h1;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		rdchk(`HEF_OFS_FLAGS, 32'h0);
		rdchk(`HEF_OFS_ENABLES, 32'h0);
		chk({31'h0, irq}, 32'h0);
		$display("test done: reset values");
		u_cpu.wr(`HEF_OFS_ENABLES, 32'hffff_ffff, rs);
		for (int i = 0; i < 8; i++) begin
			pulse(i);
			rdchk(`HEF_OFS_FLAGS, exp_word[i]);
			chk({31'h0, irq}, 32'h1);
			u_cpu.wr(`HEF_OFS_FLAGS, exp_word[i], rs);
			rdchk(`HEF_OFS_FLAGS, 32'h0);
			chk({31'h0, irq}, 32'h0);
		end
		$display("test done: event table");
		u_cpu.wr(`HEF_OFS_ENABLES, 32'h0, rs);
		pulse(6);
		chk({31'h0, irq}, 32'h0);
		u_cpu.stall = 3;
		rdchk(`HEF_OFS_FLAGS, 32'h8);
		u_cpu.wr(`HEF_OFS_ENABLES, 32'h8, rs);
		chk({31'h0, irq}, 32'h1);
		u_cpu.wr(`HEF_OFS_ENABLES, 32'h400, rs);
		chk({31'h0, irq}, 32'h0);
		rdchk(`HEF_OFS_ENABLES, 32'h400);
		u_cpu.stall = 0;
		u_cpu.wr(`HEF_OFS_ENABLES, 32'h0, rs);
		u_cpu.wr(`HEF_OFS_FLAGS, 32'h8, rs);
		$display("test done: enable gating");
		for (int k = 0; k < 3; k++) begin
			u_cpu.wr(`HEF_OFS_ISO_AND + 12'(8 * k), 32'ha, rs);
			dv <= 32'h2;
			pulse(1 + k);
			rdchk(`HEF_OFS_FLAGS, 32'h0);
			dv <= 32'h8;
			pulse(1 + k);
			rdchk(`HEF_OFS_FLAGS, exp_word[1 + k]);
			u_cpu.wr(`HEF_OFS_ISO_AND + 12'(8 * k), 32'h0, rs);
			u_cpu.wr(`HEF_OFS_FLAGS, exp_word[1 + k], rs);
		end
		u_cpu.wr(`HEF_OFS_INT_OR, 32'h8, rs);
		dv <= 32'h2;
		pulse(3);
		rdchk(`HEF_OFS_FLAGS, 32'h0);
		dv <= 32'h8;
		pulse(3);
		rdchk(`HEF_OFS_FLAGS, 32'h80);
		$display("test done: and masks");
		u_cpu.wr(12'h3f0, 32'h2, rs);
		chk({30'h0, rs}, {30'h0, `HEF_RESP_SLVERR});
		u_cpu.rd(12'h3f0, rv, rs);
		chk({30'h0, rs}, {30'h0, `HEF_RESP_SLVERR});
		chk(rv, 32'h0);
		$display("test done: unmapped");
		u_cpu.wr(`HEF_OFS_ENABLES, 32'h2, rs);
		pulse(7);
		chk({31'h0, irq}, 32'h1);
		rdchk(`HEF_OFS_LEVELS, 32'h4);
		chk({30'h0, rs}, {30'h0, `HEF_RESP_OKAY});
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		chk({31'h0, irq}, 32'h0);
		rdchk(`HEF_OFS_FLAGS, 32'h0);
		rdchk(`HEF_OFS_ENABLES, 32'h0);
		$display("test done: mid-run reset");
		summarize();
	end
endmodule // host_event_status_flags_test
